// ### hdl/acpmux.sv
// Overview of operation
// - PLL reference: mclk, bclk, gp, din pins
// - Codec clock: mclk, bclk or gp pin
// - Data-in pin: audio input or general input
// - Direction bits make bclk and wclk outputs
// - Data-out pin selects one of seven outputs
// - Fourth pin selects one of eight outputs
// - General pin selects input or output role
// - Third pin: secondary-port input or general input
// - Secondary inputs come from third or general pin
`timescale 1ns/100ps
module acpmux (
    input  wire logic       clock,
    input  wire logic       rst_b,
    // Register port
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Pin inputs
    input  wire logic       mclk_in,
    input  wire logic       bclk_in,
    input  wire logic       wclk_in,
    input  wire logic       data_in_multi_pin_in,
    input  wire logic       third_multi_pin_in,
    input  wire logic       general_multi_pin_in,
    // Internal sources for outputs
    input  wire logic       bclk_int,
    input  wire logic       wclk_int,
    input  wire logic       dout_int,
    input  wire logic       gpo_val,
    input  wire logic       aux_clk,
    input  wire logic       first_interrupt_out,
    input  wire logic       second_interrupt_out,
    input  wire logic       adc_wclk_int,
    input  wire logic       sec_dout_int,
    input  wire logic       sec_bclk_int,
    input  wire logic       sec_wclk_int,
    // Pin drivers
    output logic            bclk_out,
    output logic            bclk_oe,
    output logic            wclk_out,
    output logic            wclk_oe,
    output logic            data_out_multi_pin,
    output logic            data_out_multi_pin_oe,
    output logic            fourth_multi_pin,
    output logic            fourth_multi_pin_oe,
    output logic            general_multi_pin_out,
    output logic            general_multi_pin_oe,
    // Routed internal functions
    output logic            pll_ref,
    output logic            codec_clk,
    output logic            audio_bclk,
    output logic            audio_wclk,
    output logic            audio_din,
    output logic            gpi_data_in,
    output logic            gpi_third,
    output logic            gpi_general,
    output logic            sec_bclk,
    output logic            sec_wclk,
    output logic            adc_wclk,
    output logic            sec_din
);
    import acpmux_pkg::*;

    // --------------------------------------------------------------------
    // State
    // --------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] clk_sel;
        logic [7:0] dir;
        logic [7:0] sec_src;
        logic [7:0] gp_fn;
        logic [7:0] do_fn;
        logic [7:0] di_fn;
        logic [7:0] fp_fn;
        logic [7:0] tp_fn;
        logic [5:0] s1;     // First synchroniser stage of the six pins
        logic [5:0] s2;     // Second stage, the only one logic reads
        logic [7:0] rdata;
        logic [9:0] drv;    // {bclk,wclk,do,fp,gp} value/enable pairs
        logic [11:0] fn;    // Routed internal functions
    } acpmux_s;

    acpmux_s st;
    acpmux_s next_st;

    logic m, b, w, di, tp, gp;
    assign {m, b, w, di, tp, gp} = st.s2;

    // --------------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------------
    always_comb begin
        logic dv, de, fv, fe, gv, ge, pr, cc;
        logic tp_en, gp_en;
        // Locals start from a known value on every pass, so no path leaves a latch
        dv    = 1'b0;
        de    = 1'b0;
        fv    = 1'b0;
        fe    = 1'b0;
        gv    = 1'b0;
        ge    = 1'b0;
        pr    = 1'b0;
        cc    = 1'b0;
        tp_en = 1'b0;
        gp_en = 1'b0;
        next_st = st;
        // Pins cross from outside into the clock domain
        next_st.s1 = {mclk_in, bclk_in, wclk_in, data_in_multi_pin_in,
                      third_multi_pin_in, general_multi_pin_in};
        next_st.s2 = st.s1;
        // Register writes
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_CLOCK_SOURCE_SELECT:   next_st.clk_sel = reg_wdata;
                OFS_AUDIO_PORT_DIRECTION:  next_st.dir     = reg_wdata;
                OFS_SECONDARY_PORT_SOURCE: next_st.sec_src = reg_wdata;
                OFS_GP_PIN_FUNCTION:       next_st.gp_fn   = reg_wdata;
                OFS_DATA_OUT_PIN_FUNCTION: next_st.do_fn   = reg_wdata;
                OFS_DATA_IN_PIN_FUNCTION:  next_st.di_fn   = reg_wdata;
                OFS_FOURTH_PIN_FUNCTION:   next_st.fp_fn   = reg_wdata;
                OFS_THIRD_PIN_FUNCTION:    next_st.tp_fn   = reg_wdata;
                default: ;  // Unmapped writes are dropped
            endcase
        end
        // Read data shows the stored configuration
        unique case (reg_addr)
            OFS_CLOCK_SOURCE_SELECT:   next_st.rdata = st.clk_sel;
            OFS_AUDIO_PORT_DIRECTION:  next_st.rdata = st.dir;
            OFS_SECONDARY_PORT_SOURCE: next_st.rdata = st.sec_src;
            OFS_GP_PIN_FUNCTION:       next_st.rdata = st.gp_fn;
            OFS_DATA_OUT_PIN_FUNCTION: next_st.rdata = st.do_fn;
            OFS_DATA_IN_PIN_FUNCTION:  next_st.rdata = st.di_fn;
            OFS_FOURTH_PIN_FUNCTION:   next_st.rdata = st.fp_fn;
            OFS_THIRD_PIN_FUNCTION:    next_st.rdata = st.tp_fn;
            default:                   next_st.rdata = 8'h00;
        endcase
        // Data-out pin; undefined 000 leaves it idle
        dv = 1'b0;
        de = 1'b1;
        unique case (st.do_fn[3:1])
            DO_DATA: dv = dout_int;
            DO_GPO:  dv = gpo_val;
            DO_AUX:  dv = aux_clk;
            DO_FIRST_INTERRUPT_OUT: dv = first_interrupt_out;
            DO_SECOND_INTERRUPT_OUT: dv = second_interrupt_out;
            DO_SBCK: dv = sec_bclk_int;
            DO_SWCK: dv = sec_wclk_int;
            default: de = 1'b0;
        endcase
        // Fourth pin
        fv = 1'b0;
        fe = 1'b1;
        unique case (st.fp_fn[4:1])
            FP_GPO:  fv = gpo_val;
            FP_AUX:  fv = aux_clk;
            FP_FIRST_INTERRUPT_OUT: fv = first_interrupt_out;
            FP_SECOND_INTERRUPT_OUT: fv = second_interrupt_out;
            FP_AWCK: fv = adc_wclk_int;
            FP_SDAT: fv = sec_dout_int;
            FP_SBCK: fv = sec_bclk_int;
            FP_SWCK: fv = sec_wclk_int;
            default: fe = 1'b0;
        endcase
        // General pin: output roles drive, input roles open the input
        gv = 1'b0;
        ge = 1'b1;
        gp_en = 1'b0;
        unique case (st.gp_fn[5:2])
            GP_CLKIN: begin
                ge = 1'b0;
                gp_en = 1'b1;
            end
            GP_GPI: ge = 1'b0;
            GP_GPO:  gv = gpo_val;
            GP_AUX:  gv = aux_clk;
            GP_FIRST_INTERRUPT_OUT: gv = first_interrupt_out;
            GP_SECOND_INTERRUPT_OUT: gv = second_interrupt_out;
            GP_AWCK: gv = adc_wclk_int;
            GP_SBCK: gv = sec_bclk_int;
            GP_SWCK: gv = sec_wclk_int;
            default: ge = 1'b0;
        endcase
        tp_en = (st.tp_fn[2:1] == IN_AUDIO);
        // Clock selection; a source pin disabled for clock input gives 0
        unique case (st.clk_sel[3:2])
            SRC_MCLK: pr = m;
            SRC_BCLK: pr = b;
            SRC_GP:   pr = gp & gp_en;
            SRC_DIN:  pr = di & (st.di_fn[2:1] == IN_AUDIO);
        endcase
        unique case (st.clk_sel[1:0])
            SRC_MCLK: cc = m;
            SRC_BCLK: cc = b;
            SRC_GP:   cc = gp & gp_en;
            default:  cc = 1'b0;
        endcase
        next_st.drv = {bclk_int, st.dir[3], wclk_int, st.dir[2],
                       dv, de, fv, fe, gv, ge};
        next_st.fn = {pr, cc,
                      b & ~st.dir[3],
                      w & ~st.dir[2],
                      di & (st.di_fn[2:1] == IN_AUDIO),
                      di & (st.di_fn[2:1] == IN_GEN),
                      tp & (st.tp_fn[2:1] == IN_GEN),
                      gp & (st.gp_fn[5:2] == GP_GPI),
                      // Secondary inputs from third pin or general pin
                      (st.sec_src[6:5] == SP_THIRD) ? tp & tp_en :
                      (st.sec_src[6:5] == SP_GP) ? gp & gp_en : 1'b0,
                      (st.sec_src[4:3] == SP_THIRD) ? tp & tp_en :
                      (st.sec_src[4:3] == SP_GP) ? gp & gp_en : 1'b0,
                      (st.sec_src[2:1] == SP_THIRD) ? tp & tp_en :
                      (st.sec_src[2:1] == SP_GP) ? gp & gp_en : 1'b0,
                      st.sec_src[0] ? tp & tp_en : gp & gp_en};
    end

    // --------------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops; one cycle of latency is accepted
    assign reg_rdata = st.rdata;
    assign {bclk_out, bclk_oe, wclk_out, wclk_oe, data_out_multi_pin, data_out_multi_pin_oe,
            fourth_multi_pin, fourth_multi_pin_oe, general_multi_pin_out, general_multi_pin_oe} = st.drv;
    assign {pll_ref, codec_clk, audio_bclk, audio_wclk, audio_din, gpi_data_in,
            gpi_third, gpi_general, sec_bclk, sec_wclk, adc_wclk, sec_din} = st.fn;

    // --------------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------------
    property p_bclk_dir;
        @(posedge clock) disable iff (!rst_b) bclk_oe |-> $past(st.dir[3]);
    endproperty
    a_bclk_dir: assert property (p_bclk_dir) else $error("bclk driven while input");

    property p_do_idle;
        @(posedge clock) disable iff (!rst_b) (st.do_fn[3:1] == 3'h0) |=> !data_out_multi_pin_oe;
    endproperty
    a_do_idle: assert property (p_do_idle) else $error("data-out pin driven on code 000");

    property p_do_first_interrupt_out;
        @(posedge clock) disable iff (!rst_b)
            (st.do_fn[3:1] == DO_FIRST_INTERRUPT_OUT) |=> data_out_multi_pin == $past(first_interrupt_out);
    endproperty
    a_do_first_interrupt_out: assert property (p_do_first_interrupt_out) else $error("data-out pin not carrying interrupt");

    property p_fp_awck;
        @(posedge clock) disable iff (!rst_b)
            (st.fp_fn[4:1] == FP_AWCK) |=> fourth_multi_pin_oe && fourth_multi_pin == $past(adc_wclk_int);
    endproperty
    a_fp_awck: assert property (p_fp_awck) else $error("fourth pin wrong");

    property p_gp_in;
        @(posedge clock) disable iff (!rst_b) (st.gp_fn[5:2] == GP_GPI) |=> !general_multi_pin_oe;
    endproperty
    a_gp_in: assert property (p_gp_in) else $error("general pin driven as input");

    property p_pll_mclk;
        @(posedge clock) disable iff (!rst_b) (st.clk_sel[3:2] == SRC_MCLK) |=> pll_ref == $past(m);
    endproperty
    a_pll_mclk: assert property (p_pll_mclk) else $error("pll ref not mclk");

    property p_cc_bclk;
        @(posedge clock) disable iff (!rst_b) (st.clk_sel[1:0] == SRC_BCLK) |=> codec_clk == $past(b);
    endproperty
    a_cc_bclk: assert property (p_cc_bclk) else $error("codec clock not bclk");

    property p_din_off;
        @(posedge clock) disable iff (!rst_b) (st.di_fn[2:1] != IN_AUDIO) |=> !audio_din;
    endproperty
    a_din_off: assert property (p_din_off) else $error("audio input while disabled");

    property p_sdin_third;
        @(posedge clock) disable iff (!rst_b)
            (st.sec_src[0] && st.tp_fn[2:1] == IN_AUDIO) |=> sec_din == $past(tp);
    endproperty
    a_sdin_third: assert property (p_sdin_third) else $error("secondary data not from third pin");

    property p_third_gpi;
        @(posedge clock) disable iff (!rst_b) (st.tp_fn[2:1] != IN_GEN) |=> !gpi_third;
    endproperty
    a_third_gpi: assert property (p_third_gpi) else $error("third pin input while off");

endmodule : acpmux

// ### hdl/acpmux_pkg.sv
package acpmux_pkg;

    // --------------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------------
    localparam logic [7:0] OFS_CLOCK_SOURCE_SELECT = 8'h04;
    localparam logic [7:0] OFS_AUDIO_PORT_DIRECTION = 8'h1b;
    localparam logic [7:0] OFS_SECONDARY_PORT_SOURCE = 8'h1f;
    localparam logic [7:0] OFS_GP_PIN_FUNCTION = 8'h34;
    localparam logic [7:0] OFS_DATA_OUT_PIN_FUNCTION = 8'h35;
    localparam logic [7:0] OFS_DATA_IN_PIN_FUNCTION = 8'h36;
    localparam logic [7:0] OFS_FOURTH_PIN_FUNCTION = 8'h37;
    localparam logic [7:0] OFS_THIRD_PIN_FUNCTION = 8'h38;

    // --------------------------------------------------------------------
    // Reset values (all pins idle: inputs, no function)
    // --------------------------------------------------------------------
    localparam logic [7:0] RST_REG = 8'h00;

    // --------------------------------------------------------------------
    // Field codes
    // --------------------------------------------------------------------
    localparam logic [1:0] SRC_MCLK = 2'h0;
    localparam logic [1:0] SRC_BCLK = 2'h1;
    localparam logic [1:0] SRC_GP   = 2'h2;
    localparam logic [1:0] SRC_DIN  = 2'h3;

    localparam logic [1:0] IN_AUDIO = 2'h1;
    localparam logic [1:0] IN_GEN   = 2'h2;

    localparam logic [2:0] DO_DATA = 3'h1;
    localparam logic [2:0] DO_GPO  = 3'h2;
    localparam logic [2:0] DO_AUX  = 3'h3;
    localparam logic [2:0] DO_FIRST_INTERRUPT_OUT = 3'h4;
    localparam logic [2:0] DO_SECOND_INTERRUPT_OUT = 3'h5;
    localparam logic [2:0] DO_SBCK = 3'h6;
    localparam logic [2:0] DO_SWCK = 3'h7;

    localparam logic [3:0] FP_GPO  = 4'h2;
    localparam logic [3:0] FP_AUX  = 4'h3;
    localparam logic [3:0] FP_FIRST_INTERRUPT_OUT = 4'h4;
    localparam logic [3:0] FP_SECOND_INTERRUPT_OUT = 4'h5;
    localparam logic [3:0] FP_AWCK = 4'h6;
    localparam logic [3:0] FP_SDAT = 4'h8;
    localparam logic [3:0] FP_SBCK = 4'h9;
    localparam logic [3:0] FP_SWCK = 4'ha;

    localparam logic [3:0] GP_CLKIN = 4'h1;
    localparam logic [3:0] GP_GPI   = 4'h2;
    localparam logic [3:0] GP_GPO   = 4'h3;
    localparam logic [3:0] GP_AUX   = 4'h4;
    localparam logic [3:0] GP_FIRST_INTERRUPT_OUT  = 4'h5;
    localparam logic [3:0] GP_SECOND_INTERRUPT_OUT  = 4'h6;
    localparam logic [3:0] GP_AWCK  = 4'h7;
    localparam logic [3:0] GP_SBCK  = 4'h8;
    localparam logic [3:0] GP_SWCK  = 4'h9;

    localparam logic [1:0] SP_THIRD = 2'h1;
    localparam logic [1:0] SP_GP    = 2'h0;

endpackage : acpmux_pkg

// ### verif/acpmux_host.sv
`timescale 1ns/100ps
module acpmux_host (
    input  wire logic       clock,
    output logic            reg_wr,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // ------------------------------------------------------------
    // Idle control bus
    // ------------------------------------------------------------
    initial begin
        reg_wr    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // ------------------------------------------------------------
    // Bus cycles, launched on the falling edge
    // ------------------------------------------------------------
    // Each write sets one whole register, which can give roles to several pins at once
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr    = 1'b0;
        reg_wdata = ~d;  // Stale data must not pass for valid data
    endtask : write_reg

    // Read data is registered, so it is taken one edge after the address
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        @(negedge clock);
        d = reg_rdata;
    endtask : read_reg
endmodule : acpmux_host

// ### verif/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, gt) cmp(nm, 32'(ex), 32'(gt))
module tb_top;
    import acpmux_pkg::*;
    logic        clock;
    logic        rst_b;
    logic [5:0]  pins;      // general, third, din, wclk, bclk, mclk
    logic [10:0] src;       // Internal sources, index order of the instance map
    logic        reg_wr;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic [11:0] r;         // Routed functions
    logic [4:0]  o;         // Pin values: general, fourth, data-out, wclk, bclk
    logic [4:0]  oe;
    logic [7:0]  rd;
    int          num_errors = 0;
    int          n_tests = 0;

    acpmux_host acpmux_host_i (.clock(clock), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    acpmux acpmux_i (.clock(clock), .rst_b(rst_b), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .mclk_in(pins[0]), .bclk_in(pins[1]), .wclk_in(pins[2]),
        .data_in_multi_pin_in(pins[3]), .third_multi_pin_in(pins[4]), .general_multi_pin_in(pins[5]),
        .bclk_int(src[0]), .wclk_int(src[1]), .dout_int(src[2]), .gpo_val(src[3]), .aux_clk(src[4]),
        .first_interrupt_out(src[5]), .second_interrupt_out(src[6]), .adc_wclk_int(src[7]),
        .sec_dout_int(src[8]), .sec_bclk_int(src[9]), .sec_wclk_int(src[10]),
        .bclk_out(o[0]), .bclk_oe(oe[0]), .wclk_out(o[1]), .wclk_oe(oe[1]),
        .data_out_multi_pin(o[2]), .data_out_multi_pin_oe(oe[2]), .fourth_multi_pin(o[3]),
        .fourth_multi_pin_oe(oe[3]), .general_multi_pin_out(o[4]), .general_multi_pin_oe(oe[4]),
        .pll_ref(r[0]), .codec_clk(r[1]), .audio_bclk(r[2]), .audio_wclk(r[3]), .audio_din(r[4]),
        .gpi_data_in(r[5]), .gpi_third(r[6]), .gpi_general(r[7]), .sec_bclk(r[8]), .sec_wclk(r[9]),
        .adc_wclk(r[10]), .sec_din(r[11]));

    // ------------------------------------------------------------
    // Clock and common helpers
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] gt);
        n_tests++;
        if (gt !== ex) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, ex, gt);
        end
    endtask : cmp

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // Covers two sync stages plus the output register
    task automatic settle;
        repeat (4) @(negedge clock);
    endtask : settle

    task automatic cfg(input logic [7:0] gp, din, third, sec);
        acpmux_host_i.write_reg(OFS_GP_PIN_FUNCTION, gp);
        acpmux_host_i.write_reg(OFS_DATA_IN_PIN_FUNCTION, din);
        acpmux_host_i.write_reg(OFS_THIRD_PIN_FUNCTION, third);
        acpmux_host_i.write_reg(OFS_SECONDARY_PORT_SOURCE, sec);
    endtask : cfg

    task automatic chk_in(input logic [5:0] p, input logic [11:0] ex);
        pins = p;
        settle();
        `CHK("routed", ex, r);
    endtask : chk_in

    // Source index for an output code, -1 where the code drives no output
    function automatic int map_src(input int pin, input int c);
        case (pin)
            2: return (c >= 1 && c <= 5) ? c + 1 : (c >= 6 ? c + 3 : -1);
            3: return (c >= 2 && c <= 6) ? c + 1 : ((c >= 8 && c <= 10) ? c : -1);
            default: return (c >= 3 && c <= 7) ? c : ((c == 8 || c == 9) ? c + 1 : -1);
        endcase
    endfunction : map_src

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [7:0] ofs [8] = '{8'h04, 8'h1b, 8'h1f, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38};
        `CHK("oe after reset", 5'h00, oe);
        `CHK("routed after reset", 12'h000, r);
        foreach (ofs[i]) acpmux_host_i.write_reg(ofs[i], 8'h5a ^ ofs[i]);
        acpmux_host_i.write_reg(8'h05, 8'hff);
        foreach (ofs[i]) begin
            acpmux_host_i.read_reg(ofs[i], rd);
            `CHK("readback", 8'h5a ^ ofs[i], rd);
        end
        acpmux_host_i.read_reg(8'h05, rd);
        `CHK("unmapped", 8'h00, rd);
        foreach (ofs[i]) acpmux_host_i.write_reg(ofs[i], 8'h00);
    endtask : t_regs

    task automatic t_clk_src;
        int pin_bit [4] = '{0, 1, 5, 3};
        cfg(8'h04, 8'h02, 8'h00, 8'h00);
        for (int s = 0; s < 4; s++) begin
            acpmux_host_i.write_reg(OFS_CLOCK_SOURCE_SELECT, 8'((s << 2) | s));
            for (int k = 0; k < 4; k++) begin
                pins = 6'(1 << pin_bit[k]);
                settle();
                `CHK("pll_ref", k == s, r[0]);
                `CHK("codec_clk", k == s && s != 3, r[1]);
            end
        end
        acpmux_host_i.write_reg(OFS_CLOCK_SOURCE_SELECT, 8'h00);
    endtask : t_clk_src

    task automatic t_inputs;
        cfg(8'h00, 8'h02, 8'h00, 8'h00);
        chk_in(6'h08, 12'h010);
        cfg(8'h00, 8'h04, 8'h04, 8'h00);
        chk_in(6'h18, 12'h060);
        cfg(8'h08, 8'h06, 8'h00, 8'h00);
        chk_in(6'h28, 12'h080);
        cfg(8'h00, 8'h00, 8'h02, 8'h2b);
        chk_in(6'h10, 12'hf00);
        chk_in(6'h20, 12'h000);
        cfg(8'h04, 8'h00, 8'h00, 8'h00);
        chk_in(6'h20, 12'hf00);
        chk_in(6'h10, 12'h000);
        cfg(8'h00, 8'h00, 8'h00, 8'h00);
    endtask : t_inputs

    task automatic t_direction;
        chk_in(6'h06, 12'h00c);
        `CHK("dir oe in", 2'b00, oe[1:0]);
        acpmux_host_i.write_reg(OFS_AUDIO_PORT_DIRECTION, 8'h08);
        src = 11'h001;
        chk_in(6'h06, 12'h008);
        `CHK("dir oe bclk", 2'b01, oe[1:0]);
        `CHK("bclk_out", 1'b1, o[0]);
        acpmux_host_i.write_reg(OFS_AUDIO_PORT_DIRECTION, 8'h04);
        src = 11'h002;
        chk_in(6'h06, 12'h004);
        `CHK("dir oe wclk", 2'b10, oe[1:0]);
        `CHK("wclk_out", 1'b1, o[1]);
        acpmux_host_i.write_reg(OFS_AUDIO_PORT_DIRECTION, 8'h00);
        pins = 6'h00;
    endtask : t_direction

    task automatic t_out_mux(input int pin, input logic [7:0] a, input int sh, input int ncode);
        int idx;
        for (int c = 0; c < ncode; c++) begin
            idx = map_src(pin, c);
            acpmux_host_i.write_reg(a, 8'(c << sh));
            src = (idx >= 0) ? 11'(1 << idx) : 11'h7ff;
            settle();
            `CHK("pin oe", idx >= 0, oe[pin]);
            if (idx >= 0) begin
                `CHK("pin high", 1'b1, o[pin]);
                src = ~11'(1 << idx);
                settle();
                `CHK("pin low", 1'b0, o[pin]);
            end
        end
        acpmux_host_i.write_reg(a, 8'h00);
    endtask : t_out_mux

    // A reset in mid-run must drop every pin driver and clear the configuration
    task automatic t_reset;
        acpmux_host_i.write_reg(OFS_DATA_OUT_PIN_FUNCTION, 8'h02);
        acpmux_host_i.write_reg(OFS_AUDIO_PORT_DIRECTION, 8'h0c);
        settle();
        `CHK("oe before reset", 5'h07, oe);
        rst_b = 1'b0;
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        `CHK("oe after mid reset", 5'h00, oe);
        acpmux_host_i.read_reg(OFS_DATA_OUT_PIN_FUNCTION, rd);
        `CHK("config after reset", RST_REG, rd);
    endtask : t_reset

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        pins  = 6'h00;
        src   = 11'h000;
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        t_regs();
        t_clk_src();
        t_inputs();
        t_direction();
        t_out_mux(2, OFS_DATA_OUT_PIN_FUNCTION, 1, 8);
        t_out_mux(3, OFS_FOURTH_PIN_FUNCTION, 1, 16);
        t_out_mux(4, OFS_GP_PIN_FUNCTION, 2, 16);
        t_reset();
        tally_and_finish();
    end

    // A hang can only come from a stuck sequence, so a fixed budget suffices
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        tally_and_finish();
    end
endmodule : tb_top
